/* File: rtl/scp_pkg.sv */
// scp_pkg: constants, field layout and types of the serial config port.
// assumes: shared by scp_serial_config_port and scp_sync, nothing imported.
package scp_pkg;

	localparam int          SCP_WORD_W     = 15;
	localparam int          SCP_CNT_W      = 4;
	localparam int          SCP_SYNC_W     = 3;
	localparam logic [3:0]  SCP_LAST_BIT   = 4'hf;
	localparam logic [3:0]  SCP_CNT_RST    = 4'h0;

	// bus offsets, byte addresses
	localparam logic [3:0]  SCP_OFS_CFG    = 4'h0;
	localparam logic [3:0]  SCP_OFS_STATUS = 4'h4;
	localparam logic [3:0]  SCP_OFS_CTRL   = 4'h8;

	// values after reset
	localparam logic [14:0] SCP_CFG_RST    = 15'h0000;
	localparam logic        SCP_EN_RST     = 1'h1;
	localparam logic [7:0]  SCP_WRCNT_RST  = 8'h00;
	// sync stages for {sclk, sdata, gate_n}: gate idles high, no fake frame
	localparam logic [2:0]  SCP_LINK_RST   = 3'h1;

	// configuration word field positions
	localparam int          SCP_POS_DCDIS  = 0;
	localparam int          SCP_POS_OUTG   = 1;
	localparam int          SCP_POS_POSTG  = 2;
	localparam int          SCP_POS_MIDG   = 4;
	localparam int          SCP_POS_VGA1G  = 6;
	localparam int          SCP_POS_PWR    = 8;
	localparam int          SCP_POS_CORNER = 9;
	localparam logic [5:0]  SCP_CORNER_BYP = 6'h00;

	// status and control bit positions
	localparam int          SCP_ST_BUSY    = 0;
	localparam int          SCP_ST_LASTWR  = 1;
	localparam int          SCP_ST_SHORT   = 2;
	localparam int          SCP_ST_WRCNT   = 8;
	localparam int          SCP_CT_EN      = 0;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CMD,
		ST_WRITE,
		ST_READ
	} scp_state_t;

	// decoded settings, one set for both channels
	typedef struct packed {
		logic [5:0] corner_mhz;
		logic       filter_bypass;
		logic       power_high;
		logic [1:0] vga1_gain;
		logic [1:0] mid_gain;
		logic [1:0] post_gain;
		logic       out_gain;
		logic       dc_loop_dis;
	} scp_cfg_t;

	typedef struct packed {
		logic sclk;
		logic sdata;
		logic gate_n;
	} scp_link_t;

endpackage : scp_pkg

/* File: rtl/scp_serial_config_port.sv */
// scp_serial_config_port: three-wire config port with an Avalon-MM slave.
// assumes: link pins asynchronous and much slower than clk_sys_in (250 MHz);
// the host frames each cycle with transfer_gate_n_in low.
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ns

module scp_serial_config_port #(
	parameter int WORD_BITS = scp_pkg::SCP_WORD_W
) (
	input  wire logic             clk_sys_in,        // system clock
	input  wire logic             reset_n_in,        // sync reset, active low
	input  wire logic [3:0]       avs_address_in,    // byte address
	input  wire logic             avs_read_in,       // read request
	input  wire logic             avs_write_in,      // write request
	input  wire logic [31:0]      avs_writedata_in,  // write data
	input  wire logic [3:0]       avs_byteenable_in, // byte lanes
	output logic      [31:0]      avs_readdata_out,  // read data
	output logic                  avs_waitrequest_out, // stall
	input  wire logic             sclk_in,           // link clock pin
	input  wire logic             sdata_in,          // link data pin
	input  wire logic             transfer_gate_n_in, // frame, active low
	output logic                  serial_out_dual_pin_out, // read data
	output logic                  serial_out_dual_pin_oe_n_out, // drive
	output scp_pkg::scp_cfg_t     cfg_out,           // applied settings
	output logic                  busy_out           // frame in progress
);

	if (WORD_BITS != 15) begin : g_chk
		$error("scp_serial_config_port: word must be 15 bits");
	end

	function automatic scp_pkg::scp_cfg_t decode_cfg(input logic [14:0] w);
		scp_pkg::scp_cfg_t f;
		f.corner_mhz    = w[scp_pkg::SCP_POS_CORNER +: 6];
		f.filter_bypass = (w[scp_pkg::SCP_POS_CORNER +: 6]
		                   == scp_pkg::SCP_CORNER_BYP);
		f.power_high    = w[scp_pkg::SCP_POS_PWR];
		f.vga1_gain     = w[scp_pkg::SCP_POS_VGA1G +: 2];
		f.mid_gain      = w[scp_pkg::SCP_POS_MIDG +: 2];
		f.post_gain     = w[scp_pkg::SCP_POS_POSTG +: 2];
		f.out_gain      = w[scp_pkg::SCP_POS_OUTG];
		f.dc_loop_dis   = w[scp_pkg::SCP_POS_DCDIS];
		return f;
	endfunction : decode_cfg

	function automatic logic [31:0] be_merge(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] be);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_w[i*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	// link pins pass two flops before any logic looks at them
	scp_pkg::scp_link_t link_raw;
	scp_pkg::scp_link_t link_s;

	assign link_raw.sclk   = sclk_in;
	assign link_raw.sdata  = sdata_in;
	assign link_raw.gate_n = transfer_gate_n_in;

	scp_sync #(
		.W       (scp_pkg::SCP_SYNC_W),
		.RST_VAL (scp_pkg::SCP_LINK_RST)
	) u_sync (
		.clk_sys_in (clk_sys_in),
		.reset_n_in (reset_n_in),
		.d_in       (link_raw),
		.q_out      (link_s)
	);

	// edge finder state
	logic sclk_d_r;
	logic sclk_d_nxt;
	logic sclk_rise;
	logic sclk_fall;
	logic gate_hi;

	always_comb begin
		sclk_d_nxt = link_s.sclk;
		if (!reset_n_in) begin
			sclk_d_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		sclk_d_r <= sclk_d_nxt;
	end

	assign sclk_rise = link_s.sclk & ~sclk_d_r;
	assign sclk_fall = ~link_s.sclk & sclk_d_r;
	assign gate_hi   = link_s.gate_n;

	// bus side state
	logic        ack_r;
	logic        ack_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic        en_r;
	logic        en_nxt;
	logic        bus_wr;
	logic        sw_cfg_wr;
	logic        sw_short_clr;
	logic [31:0] cfg_wr_word;

	// link side state
	scp_pkg::scp_state_t state_r;
	scp_pkg::scp_state_t state_nxt;
	logic [3:0]  cnt_r;
	logic [3:0]  cnt_nxt;
	logic [14:0] shadow_r;
	logic [14:0] shadow_nxt;
	logic [14:0] cfg_r;
	logic [14:0] cfg_nxt;
	logic        sdo_r;
	logic        sdo_nxt;
	logic        oe_n_r;
	logic        oe_n_nxt;
	logic        short_r;
	logic        short_nxt;
	logic        lastwr_r;
	logic        lastwr_nxt;
	logic [7:0]  wrcnt_r;
	logic [7:0]  wrcnt_nxt;
	logic        link_apply;

	// one cycle stall, then the answer; write acts on the release edge
	assign bus_wr       = avs_write_in & ack_r;
	assign sw_cfg_wr    = bus_wr & (avs_address_in == scp_pkg::SCP_OFS_CFG);
	assign sw_short_clr = bus_wr
	                      & (avs_address_in == scp_pkg::SCP_OFS_STATUS)
	                      & avs_byteenable_in[0]
	                      & avs_writedata_in[scp_pkg::SCP_ST_SHORT];
	assign cfg_wr_word  = be_merge({17'h00000, cfg_r}, avs_writedata_in,
	                               avs_byteenable_in);

	always_comb begin
		ack_nxt   = (avs_read_in | avs_write_in) & ~ack_r;
		rdata_nxt = rdata_r;
		en_nxt    = en_r;
		if (avs_read_in && !ack_r) begin
			if (avs_address_in == scp_pkg::SCP_OFS_CFG) begin
				rdata_nxt = {17'h00000, cfg_r};
			end else if (avs_address_in == scp_pkg::SCP_OFS_STATUS) begin
				rdata_nxt = 32'h00000000;
				rdata_nxt[scp_pkg::SCP_ST_BUSY]   = busy_out;
				rdata_nxt[scp_pkg::SCP_ST_LASTWR] = lastwr_r;
				rdata_nxt[scp_pkg::SCP_ST_SHORT]  = short_r;
				rdata_nxt[scp_pkg::SCP_ST_WRCNT +: 8] = wrcnt_r;
			end else if (avs_address_in == scp_pkg::SCP_OFS_CTRL) begin
				rdata_nxt = {31'h00000000, en_r};
			end else begin
				rdata_nxt = 32'h00000000;
			end
		end
		if (bus_wr && avs_address_in == scp_pkg::SCP_OFS_CTRL
		    && avs_byteenable_in[0]) begin
			en_nxt = avs_writedata_in[scp_pkg::SCP_CT_EN];
		end
		if (!reset_n_in) begin
			ack_nxt   = 1'b0;
			rdata_nxt = 32'h00000000;
			en_nxt    = scp_pkg::SCP_EN_RST;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		ack_r   <= ack_nxt;
		rdata_r <= rdata_nxt;
		en_r    <= en_nxt;
	end

	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;
	assign avs_readdata_out    = rdata_r;

	// frame engine
	always_comb begin
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		shadow_nxt = shadow_r;
		cfg_nxt    = cfg_r;
		sdo_nxt    = sdo_r;
		oe_n_nxt   = oe_n_r;
		lastwr_nxt = lastwr_r;
		wrcnt_nxt  = wrcnt_r;
		link_apply = 1'b0;
		short_nxt  = short_r & ~sw_short_clr;
		case (state_r)
			scp_pkg::ST_IDLE: begin
				oe_n_nxt = 1'b1;
				sdo_nxt  = 1'b0;
				cnt_nxt  = scp_pkg::SCP_CNT_RST;
				if (!gate_hi && en_r) begin
					state_nxt = scp_pkg::ST_CMD;
				end
			end
			scp_pkg::ST_CMD: begin
				if (gate_hi) begin
					state_nxt = scp_pkg::ST_IDLE;
				end else if (sclk_rise) begin
					// leading bit picks the direction
					if (link_s.sdata) begin
						state_nxt  = scp_pkg::ST_WRITE;
						lastwr_nxt = 1'b1;
					end else begin
						state_nxt  = scp_pkg::ST_READ;
						lastwr_nxt = 1'b0;
					end
				end
			end
			scp_pkg::ST_WRITE: begin
				if (gate_hi) begin
					state_nxt = scp_pkg::ST_IDLE;
					// short frames are dropped so a glitch cannot half-load
					if (cnt_r == scp_pkg::SCP_LAST_BIT) begin
						link_apply = 1'b1;
						cfg_nxt    = shadow_r;
						wrcnt_nxt  = wrcnt_r + 8'h01;
					end else begin
						short_nxt = 1'b1;
					end
				end else if (sclk_rise && cnt_r != scp_pkg::SCP_LAST_BIT) begin
					shadow_nxt[cnt_r] = link_s.sdata;
					cnt_nxt = cnt_r + 4'h1;
				end
			end
			scp_pkg::ST_READ: begin
				if (gate_hi) begin
					state_nxt = scp_pkg::ST_IDLE;
					oe_n_nxt  = 1'b1;
				end else if (sclk_fall && cnt_r != scp_pkg::SCP_LAST_BIT) begin
					sdo_nxt  = cfg_r[cnt_r];
					oe_n_nxt = 1'b0;
					cnt_nxt  = cnt_r + 4'h1;
				end
			end
			default: begin
				state_nxt = scp_pkg::ST_IDLE;
			end
		endcase
		// link load outranks a software write in the same cycle
		if (sw_cfg_wr && !link_apply) begin
			cfg_nxt = cfg_wr_word[14:0];
		end
		if (!reset_n_in) begin
			state_nxt  = scp_pkg::ST_IDLE;
			cnt_nxt    = scp_pkg::SCP_CNT_RST;
			shadow_nxt = scp_pkg::SCP_CFG_RST;
			cfg_nxt    = scp_pkg::SCP_CFG_RST;
			sdo_nxt    = 1'b0;
			oe_n_nxt   = 1'b1;
			short_nxt  = 1'b0;
			lastwr_nxt = 1'b0;
			wrcnt_nxt  = scp_pkg::SCP_WRCNT_RST;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		state_r  <= state_nxt;
		cnt_r    <= cnt_nxt;
		shadow_r <= shadow_nxt;
		cfg_r    <= cfg_nxt;
		sdo_r    <= sdo_nxt;
		oe_n_r   <= oe_n_nxt;
		short_r  <= short_nxt;
		lastwr_r <= lastwr_nxt;
		wrcnt_r  <= wrcnt_nxt;
	end

	// one decoded copy feeds both channels
	assign cfg_out = decode_cfg(cfg_r);
	assign busy_out = (state_r != scp_pkg::ST_IDLE);
	assign serial_out_dual_pin_out      = sdo_r;
	assign serial_out_dual_pin_oe_n_out = oe_n_r;

	// checks
	logic exp_bit;
	assign exp_bit = cfg_r[cnt_r];

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_cmd_rise;
		state_r == scp_pkg::ST_CMD && !gate_hi && sclk_rise;
	endsequence

	sequence s_write_close;
		state_r == scp_pkg::ST_WRITE && gate_hi
		&& cnt_r == scp_pkg::SCP_LAST_BIT;
	endsequence

	a_start_write: assert property (
		s_cmd_rise and link_s.sdata |=> state_r == scp_pkg::ST_WRITE)
		else $error("write not started on leading one");

	a_start_read: assert property (
		s_cmd_rise and !link_s.sdata |=> state_r == scp_pkg::ST_READ)
		else $error("read not started on leading zero");

	a_write_shift: assert property (
		state_r == scp_pkg::ST_WRITE && !gate_hi && sclk_rise
		&& cnt_r != scp_pkg::SCP_LAST_BIT
		|=> cnt_r == $past(cnt_r) + 4'h1)
		else $error("write bit not counted");

	a_apply_cfg: assert property (
		s_write_close |=> cfg_r == $past(shadow_r)
		##1 state_r == scp_pkg::ST_IDLE)
		else $error("captured word not applied");

	a_read_bit: assert property (
		state_r == scp_pkg::ST_READ && !gate_hi && sclk_fall
		&& cnt_r != scp_pkg::SCP_LAST_BIT
		|=> serial_out_dual_pin_out == $past(exp_bit)
		&& !serial_out_dual_pin_oe_n_out)
		else $error("read bit wrong");

	a_read_end: assert property (
		state_r == scp_pkg::ST_READ && gate_hi
		|=> state_r == scp_pkg::ST_IDLE ##1 serial_out_dual_pin_oe_n_out)
		else $error("read not ended by gate");

	a_bypass_dec: assert property (
		(cfg_r[scp_pkg::SCP_POS_CORNER +: 6] == 6'h00)
		== cfg_out.filter_bypass)
		else $error("bypass decode wrong");

	a_gate_hold: assert property (
		gate_hi && state_r == scp_pkg::ST_IDLE && !sw_cfg_wr
		|=> $stable(cfg_r))
		else $error("config changed with gate high");

	a_dc_bit: assert property (
		cfg_out.dc_loop_dis == cfg_r[scp_pkg::SCP_POS_DCDIS]
		&& cfg_out.post_gain == cfg_r[scp_pkg::SCP_POS_POSTG +: 2])
		else $error("field decode wrong");

	a_bus_answer: assert property (
		(avs_read_in || avs_write_in) && !ack_r
		|-> avs_waitrequest_out ##1 !avs_waitrequest_out)
		else $error("bus answer not after one stall");

endmodule : scp_serial_config_port

/* File: rtl/scp_sync.sv */
// scp_sync: two flip-flop synchroniser for a group of level signals.
// assumes: inputs are asynchronous to clk_sys_in; stage one read only here.
`timescale 1ns/1ns
module scp_sync #(
	parameter int           W       = scp_pkg::SCP_SYNC_W,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_sys_in,   // system clock
	input  wire logic         reset_n_in,   // sync reset, active low
	input  wire logic [W-1:0] d_in,         // asynchronous levels
	output logic      [W-1:0] q_out         // synchronised levels
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s1_nxt;
	logic [W-1:0] s2_nxt;

	if (W < 1) begin : g_chk
		$error("scp_sync: width must be at least one");
	end

	always_comb begin
		s1_nxt = d_in;
		s2_nxt = s1_r;
		if (!reset_n_in) begin
			// idle level of each pin, so no false edge follows reset
			s1_nxt = RST_VAL;
			s2_nxt = RST_VAL;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		s1_r <= s1_nxt;
		s2_r <= s2_nxt;
	end

	assign q_out = s2_r;

endmodule : scp_sync

/* File: verif/scp_host_model.sv */
// scp_host_model: host side of the three-wire link, one frame per call.
// assumes: the bench calls frame(); the link clock stands low between frames.
`timescale 1ns/1ns
module scp_host_model (
	output logic      sclk_out,   // link clock
	output logic      sdata_out,  // link data
	output logic      gate_n_out, // frame gate, active low
	input  wire logic sdo_in,     // read-back bit from device
	input  wire logic oe_n_in     // device drives sdo, active low
);
	initial begin
		sclk_out = 1'b0;
		sdata_out = 1'b0;
		gate_n_out = 1'b1;
	end
	// g is the gate level held during the frame, n the rising edges sent
	task automatic frame(input logic wr, input logic [14:0] w,
		input int n, input logic g, output logic [14:0] q);
		q = 15'h0000;
		gate_n_out = g;
		#125;
		for (int i = 0; i < n; i++) begin
			// read frames keep the data line toggling, never a stale value
			sdata_out = (i == 0) ? wr : (wr ? w[i-1] : i[0]);
			#62;
			// undriven pin reads as unknown so it can never match
			if (i > 0 && i < 16)
				q[i-1] = oe_n_in ? 1'bx : sdo_in;
			sclk_out = 1'b1;
			#63;
			sclk_out = 1'b0;
		end
		#62;
		gate_n_out = 1'b1;
		sdata_out = ~sdata_out;
		#125;
	endtask : frame
endmodule : scp_host_model

/* File: verif/tb.sv */
// tb: register bus and link scenarios for the serial config port.
// assumes: host model drives the link; bus tasks start right after an edge.
`timescale 1ns/1ns
module tb;
	logic              clk_sys_in = 1'b0;
	logic              reset_n_in = 1'b0;
	logic [3:0]        avs_address_in = 4'h0;
	logic              avs_read_in = 1'b0;
	logic              avs_write_in = 1'b0;
	logic [31:0]       avs_writedata_in = 32'h0;
	logic [3:0]        avs_byteenable_in = 4'hf;
	logic [31:0]       avs_readdata_out;
	logic              avs_waitrequest_out;
	logic              sclk, sdata, gate_n, sdo, oe_n;
	logic              busy;
	scp_pkg::scp_cfg_t cfg_out;
	int                bad_count = 0;
	int                compares = 0;
	logic [31:0]       q;
	logic [14:0]       rq, cur;

	always #2 clk_sys_in = ~clk_sys_in;

	scp_serial_config_port scp_serial_config_port_i (
		.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
		.avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
		.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
		.avs_byteenable_in(avs_byteenable_in),
		.avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out),
		.sclk_in(sclk), .sdata_in(sdata), .transfer_gate_n_in(gate_n),
		.serial_out_dual_pin_out(sdo),
		.serial_out_dual_pin_oe_n_out(oe_n),
		.cfg_out(cfg_out), .busy_out(busy));

	scp_host_model scp_host_model_i (
		.sclk_out(sclk), .sdata_out(sdata), .gate_n_out(gate_n),
		.sdo_in(sdo), .oe_n_in(oe_n));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task final_report;
		$display("mismatches %0d of %0d compares", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report

	// one Avalon transfer; answer taken at the edge with waitrequest low
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_read_in <= !wr;
		avs_write_in <= wr;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (avs_waitrequest_out !== 1'b0 && n < 50);
		check({31'h0, avs_waitrequest_out}, 32'h0);
		q = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
		// idle edge so a following call never reassigns in this step
		@(posedge clk_sys_in);
	endtask : bus

	// bypass flag follows an all-zero corner code
	function automatic scp_pkg::scp_cfg_t exp_cfg(input logic [14:0] w);
		return {w[14:9], w[14:9] == 6'h00, w[8:0]};
	endfunction : exp_cfg

	task automatic lf(input logic wr, input logic [14:0] w, input int n,
		input logic g);
		scp_host_model_i.frame(wr, w, n, g, rq);
		repeat (10) @(posedge clk_sys_in);
		check({31'h0, busy}, 32'h0);
	endtask : lf

	task automatic cfg_is(input logic [14:0] w);
		check(32'(cfg_out), 32'(exp_cfg(w)));
		bus(1'b0, scp_pkg::SCP_OFS_CFG, 32'h0);
		check(q, {17'h0, w});
	endtask : cfg_is

	initial begin
		repeat (5) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		cfg_is(15'h0000);
		bus(1'b0, scp_pkg::SCP_OFS_STATUS, 32'h0);
		check(q, 32'h0);
		bus(1'b0, scp_pkg::SCP_OFS_CTRL, 32'h0);
		check({31'h0, q[0]}, 32'h1);
		bus(1'b0, 4'hc, 32'h0);
		check(q, 32'h0);
		for (int g = 0; g < 4; g++) begin
			cur = {6'h1f ^ 6'(g), 1'(g), 2'(g), 2'(~g), 2'(g), 1'(g), 1'(~g)};
			lf(1'b1, cur, 16, 1'b0);
			cfg_is(cur);
			lf(1'b0, 15'h0000, 16, 1'b0);
			check({17'h0, rq}, {17'h0, cur});
		end
		cur = 15'h01ff;
		lf(1'b1, cur, 16, 1'b0);
		cfg_is(cur);
		lf(1'b1, 15'h7fff, 16, 1'b1);
		cfg_is(cur);
		lf(1'b1, 15'h7fff, 10, 1'b0);
		cfg_is(cur);
		bus(1'b0, scp_pkg::SCP_OFS_STATUS, 32'h0);
		check(q, 32'h00000506);
		bus(1'b1, scp_pkg::SCP_OFS_STATUS, 32'h4);
		bus(1'b0, scp_pkg::SCP_OFS_STATUS, 32'h0);
		check({31'h0, q[2]}, 32'h0);
		cur = 15'h2a5a;
		bus(1'b1, scp_pkg::SCP_OFS_CFG, 32'hffff_2a5a);
		lf(1'b0, 15'h0000, 16, 1'b0);
		check({17'h0, rq}, {17'h0, cur});
		bus(1'b1, scp_pkg::SCP_OFS_CTRL, 32'h0);
		lf(1'b1, 15'h1234, 16, 1'b0);
		cfg_is(cur);
		bus(1'b0, scp_pkg::SCP_OFS_STATUS, 32'h0);
		check(q, 32'h00000500);
		bus(1'b1, scp_pkg::SCP_OFS_CTRL, 32'h1);
		final_report;
	end

	// whole sequence needs well under 60 us
	initial begin
		#200000;
		bad_count++;
		final_report;
	end
endmodule : tb
